// File: logic/dcks_top.sv
// clear acceptance, keypad loss and keypad stop supervisor
`timescale 1ns/10ps
`include "dcks_regs.svh"
module dcks_top
  import dcks_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = `DCKS_LOSS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sel_wr_stb,
  input wire logic [`DCKS_SEL_W-1:0] sel_wr_data,
  input wire logic comm_clear_stb,
  input wire logic keypad_clear_stb,
  input wire logic keypad_stop_stb,
  input wire logic stop_from_selected,
  input wire logic stop_unit_id,
  input wire logic release_stb,
  input wire logic release_unit_id,
  input wire dcks_mode_t op_mode,
  input wire logic keypad_jog_active,
  input wire logic serial_multidrop_mode,
  input wire logic motor_stopped,
  input wire logic [`DCKS_COAST_W-1:0] coast_stop_select,
  input wire logic other_fault_stb,
  input wire logic keypad_present,
  input wire logic external_clear_line,
  input wire logic forward_run_cmd,
  input wire logic reverse_run_cmd,
  output logic [`DCKS_SEL_W-1:0] fault_clear_stop_select_q,
  output logic fault_out_q,
  output logic panel_loss_fault_q,
  output logic panel_stop_state_q,
  output logic out_stage_en_q,
  output logic coast_q,
  output logic decel_req_q,
  output logic run_allowed_q,
  output logic thermal_clear_q,
  output logic regen_clear_q
);
  dcks_state_t state_q, state_d;
  logic [`DCKS_PIN_W-1:0] pin_s;
  logic present_s, xclr_s, run_s;
  logic present_d1_q, xclr_d1_q, run_d1_q;
  logic seen_q, stop_src_q;
  logic accept_any, refuse_idle, trip_on_loss, pstop_on;
  logic xclr_rise, clear_req, trip_ev, is_trip, release_ok;
  logic key_pstop, key_decel, jog_loss, coast_d;
  dcks_loss_if lif ();

  dcks_sync #(.W(`DCKS_PIN_W)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({keypad_present, external_clear_line, forward_run_cmd, reverse_run_cmd}),
    .q(pin_s)
  );

  dcks_loss_timer #(.LOSS_CYCLES(LOSS_CYCLES)) u_loss (
    .clk_sys(clk_sys),
    .rst(rst),
    .lif(lif.timer)
  );

  assign present_s = pin_s[`DCKS_PIN_PRESENT];
  assign xclr_s = pin_s[`DCKS_PIN_CLEAR];
  assign run_s = pin_s[`DCKS_PIN_FWD] | pin_s[`DCKS_PIN_REV];

  // selector: set by reset and by legal writes only, parameter clears never reach it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_clear_stop_select_q <= `DCKS_SEL_INIT;
    end else if (sel_wr_stb && (sel_wr_data inside {[5'h00:5'h03], [5'h0e:5'h11]})) begin
      fault_clear_stop_select_q <= sel_wr_data;
    end
  end

  assign accept_any = fault_clear_stop_select_q inside {5'h00, 5'h02, 5'h0e, 5'h10};
  assign refuse_idle = fault_clear_stop_select_q inside {5'h01, 5'h03, 5'h0f, 5'h11};
  assign trip_on_loss = fault_clear_stop_select_q inside {5'h02, 5'h03, 5'h10, 5'h11};
  assign pstop_on = fault_clear_stop_select_q >= 5'h0e;
  assign is_trip = (state_q == DCKS_ST_TRIP);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      present_d1_q <= 1'b0;
      xclr_d1_q <= 1'b0;
      run_d1_q <= 1'b0;
    end else begin
      present_d1_q <= present_s;
      xclr_d1_q <= xclr_s;
      run_d1_q <= run_s;
    end
  end

  // a keypad missing since power-on never arms the timer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (present_s) begin
      seen_q <= 1'b1;
    end
  end

  assign lif.arm = trip_on_loss && !serial_multidrop_mode && seen_q && !present_s
    && !is_trip;

  assign xclr_rise = xclr_s && !xclr_d1_q;
  assign clear_req = ((xclr_rise || comm_clear_stb) && (accept_any || is_trip))
    || (keypad_clear_stb && is_trip);
  assign trip_ev = other_fault_stb || lif.expired;
  assign release_ok = release_stb && (release_unit_id == stop_src_q) && motor_stopped
    && !run_s;

  // keypad stop steering by selector and operating mode
  always_comb begin
    key_pstop = 1'b0;
    key_decel = 1'b0;
    if (keypad_stop_stb) begin
      if (op_mode == DCKS_MODE_KEYPAD) begin
        if (stop_from_selected) begin
          key_decel = 1'b1;
        end else if (pstop_on) begin
          key_pstop = 1'b1;
        end else begin
          key_decel = 1'b1;
        end
      end else if (pstop_on) begin
        key_pstop = 1'b1;
      end
    end
  end

  assign jog_loss = present_d1_q && !present_s && !trip_on_loss && keypad_jog_active
    && (op_mode == DCKS_MODE_KEYPAD);

  // trip beats clear in the same cycle, so an event is never lost
  always_comb begin
    state_d = state_q;
    if (trip_ev) begin
      state_d = DCKS_ST_TRIP;
    end else if (clear_req) begin
      state_d = DCKS_ST_NORMAL;
    end else begin
      case (state_q)
        DCKS_ST_NORMAL: begin
          if (key_pstop) begin
            state_d = DCKS_ST_PSTOP;
          end else if (key_decel || jog_loss) begin
            state_d = DCKS_ST_DECEL;
          end
        end
        DCKS_ST_DECEL: begin
          if (key_pstop) begin
            state_d = DCKS_ST_PSTOP;
          end else if (motor_stopped) begin
            state_d = DCKS_ST_NORMAL;
          end
        end
        DCKS_ST_PSTOP: begin
          if (release_ok) begin
            state_d = DCKS_ST_NORMAL;
          end
        end
        DCKS_ST_TRIP: state_d = DCKS_ST_TRIP;
        default: state_d = DCKS_ST_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= DCKS_ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stop_src_q <= 1'b0;
    end else if (state_q != DCKS_ST_PSTOP && state_d == DCKS_ST_PSTOP) begin
      stop_src_q <= stop_unit_id;
    end
  end

  // run-command drop may coast; stop-key stops never do since they leave normal
  assign coast_d = clear_req
    || (state_q == DCKS_ST_NORMAL && state_d == DCKS_ST_NORMAL && run_d1_q && !run_s
    && op_mode == DCKS_MODE_OUTSIDE && coast_stop_select != `DCKS_COAST_NONE);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_out_q <= 1'b0;
      panel_stop_state_q <= 1'b0;
      out_stage_en_q <= 1'b0;
      coast_q <= 1'b0;
      decel_req_q <= 1'b0;
      run_allowed_q <= 1'b0;
    end else begin
      fault_out_q <= (state_d == DCKS_ST_TRIP);
      panel_stop_state_q <= (state_d == DCKS_ST_PSTOP);
      out_stage_en_q <= (state_d != DCKS_ST_TRIP) && !coast_d;
      coast_q <= coast_d;
      decel_req_q <= (state_d == DCKS_ST_DECEL || state_d == DCKS_ST_PSTOP)
        && !motor_stopped;
      run_allowed_q <= (state_d == DCKS_ST_NORMAL);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      thermal_clear_q <= 1'b0;
      regen_clear_q <= 1'b0;
    end else begin
      thermal_clear_q <= clear_req;
      regen_clear_q <= clear_req;
    end
  end

  // loss flag: a new loss in a clear cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      panel_loss_fault_q <= 1'b0;
    end else if (lif.expired) begin
      panel_loss_fault_q <= 1'b1;
    end else if (clear_req || other_fault_stb) begin
      panel_loss_fault_q <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sel_range_a: assert property (
    fault_clear_stop_select_q inside {[5'h00:5'h03], [5'h0e:5'h11]})
    else $error("selector outside its legal ranges");
  clear_refused_a: assert property (
    refuse_idle && !is_trip |=> !thermal_clear_q)
    else $error("clear taken while not tripped");
  clear_any_a: assert property (
    accept_any && comm_clear_stb |=> thermal_clear_q ##0 run_allowed_q || fault_out_q)
    else $error("clear not taken");
  clear_coast_a: assert property (
    thermal_clear_q |-> coast_q && !out_stage_en_q)
    else $error("clear left output stage on");
  clear_zero_a: assert property (
    thermal_clear_q == regen_clear_q)
    else $error("integrators not cleared together");
  key_clear_a: assert property (
    keypad_clear_stb && !is_trip && !comm_clear_stb && !xclr_rise |=> !thermal_clear_q)
    else $error("keypad clear acted while not tripped");
  loss_trip_a: assert property (
    lif.expired |=> fault_out_q && panel_loss_fault_q && !out_stage_en_q)
    else $error("loss did not trip");
  loss_arm_a: assert property (
    lif.arm |-> trip_on_loss && !serial_multidrop_mode && seen_q)
    else $error("loss timer armed when it must not be");
  ps_nofault_a: assert property (
    panel_stop_state_q |-> !fault_out_q)
    else $error("fault shown in panel stop");
  ps_hold_a: assert property (
    state_q == DCKS_ST_PSTOP && !release_ok && !clear_req && !trip_ev
    |=> state_q == DCKS_ST_PSTOP && panel_stop_state_q)
    else $error("panel stop left without release");
  ps_never_a: assert property (
    $rose(panel_stop_state_q) |-> $past(pstop_on))
    else $error("panel stop entered with selector 0 to 3");
  loss_hold_a: assert property (
    panel_loss_fault_q && !clear_req && !other_fault_stb |=> panel_loss_fault_q)
    else $error("loss trip dropped without clear");

  pstop_cov_c: cover property (key_pstop ##[1:50] release_ok);
  loss_cov_c: cover property (lif.expired ##[1:50] clear_req);
  jog_cov_c: cover property (jog_loss ##[1:50] motor_stopped);
  net_cov_c: cover property (key_pstop && op_mode == DCKS_MODE_NETWORK);
  clear_cov_c: cover property (clear_req && state_q == DCKS_ST_PSTOP);
endmodule

// File: logic/dcks_regs.svh
// constants of the clear and keypad stop supervisor
`ifndef DCKS_REGS_SVH
`define DCKS_REGS_SVH
`define DCKS_SEL_W 5
`define DCKS_SEL_INIT 5'h0e
`define DCKS_COAST_W 14
`define DCKS_COAST_NONE 14'h270f
`define DCKS_CLK_HZ 25000000
`define DCKS_LOSS_TIME_MS 1000
`define DCKS_LOSS_CYCLES ((`DCKS_CLK_HZ / 1000) * `DCKS_LOSS_TIME_MS)
`define DCKS_LOSS_CNT_W 25
`define DCKS_PIN_W 4
`define DCKS_PIN_PRESENT 3
`define DCKS_PIN_CLEAR 2
`define DCKS_PIN_FWD 1
`define DCKS_PIN_REV 0
`endif

// File: logic/dcks_pkg.sv
// types of the clear and keypad stop supervisor
package dcks_pkg;
  typedef enum logic [3:0] {
    DCKS_ST_NORMAL = 4'b0001,
    DCKS_ST_DECEL = 4'b0010,
    DCKS_ST_PSTOP = 4'b0100,
    DCKS_ST_TRIP = 4'b1000
  } dcks_state_t;
  typedef enum logic [2:0] {
    DCKS_MODE_KEYPAD = 3'b001,
    DCKS_MODE_OUTSIDE = 3'b010,
    DCKS_MODE_NETWORK = 3'b100
  } dcks_mode_t;
endpackage

// File: logic/dcks_loss_if.sv
// carrier between supervisor and keypad loss timer
`timescale 1ns/10ps
interface dcks_loss_if;
  logic arm;
  logic expired;
  modport ctrl (output arm, input expired);
  modport timer (input arm, output expired);
endinterface

// File: logic/dcks_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dcks_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// File: logic/dcks_loss_timer.sv
// keypad absence timer
`timescale 1ns/10ps
`include "dcks_regs.svh"
module dcks_loss_timer #(
  parameter int unsigned LOSS_CYCLES = `DCKS_LOSS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  dcks_loss_if.timer lif
);
  logic [`DCKS_LOSS_CNT_W-1:0] cnt_q;

  // saturates so a held absence fires only once
  always_ff @(posedge clk_sys) begin
    if (rst || !lif.arm) begin
      cnt_q <= '0;
    end else if (cnt_q != `DCKS_LOSS_CNT_W'(LOSS_CYCLES)) begin
      cnt_q <= cnt_q + `DCKS_LOSS_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lif.expired <= 1'b0;
    end else begin
      lif.expired <= lif.arm && (cnt_q == `DCKS_LOSS_CNT_W'(LOSS_CYCLES - 1));
    end
  end
endmodule

// File: verif/dcks_keypad_model.sv
// behavioural operator keypad and terminal pins facing the supervisor
`timescale 1ns/10ps
module dcks_keypad_model (
  input wire logic clk_sys,
  input wire logic plug_req,
  input wire logic run_req,
  input wire logic clr_req,
  output logic keypad_present,
  output logic external_clear_line,
  output logic forward_run_cmd,
  output logic reverse_run_cmd
);
  initial begin
    keypad_present = 1'b0;
    external_clear_line = 1'b0;
    forward_run_cmd = 1'b0;
    reverse_run_cmd = 1'b0;
  end
  // contacts move on clock edges only; the supervisor still has to synchronise them
  always @(posedge clk_sys) begin
    keypad_present <= plug_req;
    external_clear_line <= clr_req;
    // run is dropped before any release is tried, and raised again only after it
    forward_run_cmd <= run_req;
    reverse_run_cmd <= 1'b0;
  end
endmodule

// File: verif/tb_top.sv
// self-checking bench of the clear and keypad stop supervisor
`timescale 1ns/10ps
module tb_top;
  import dcks_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sel_wr_stb = 1'b0;
  logic [4:0] sel_wr_data = 5'h00;
  logic comm_clear_stb = 1'b0;
  logic keypad_clear_stb = 1'b0;
  logic keypad_stop_stb = 1'b0;
  logic stop_from_selected = 1'b1;
  logic stop_unit_id = 1'b1;
  logic release_stb = 1'b0;
  logic release_unit_id = 1'b1;
  dcks_mode_t op_mode = DCKS_MODE_OUTSIDE;
  logic motor_stopped = 1'b0;
  logic [13:0] coast_stop_select = 14'h0000;
  logic plug_req = 1'b0;
  logic run_req = 1'b0;
  logic clr_req = 1'b0;
  logic jog = 1'b0;
  logic mdrop = 1'b0;
  logic kp_pres, ext_clr, fwd, rev;
  logic [4:0] sel_q;
  logic fault, loss, pstop, out_en, coast, decel, run_ok, therm, regen;
  int n_fail = 0;
  int checks_done = 0;

  always #20 clk_sys = ~clk_sys;

  dcks_keypad_model u_dcks_keypad_model (.clk_sys(clk_sys), .plug_req(plug_req),
    .run_req(run_req), .clr_req(clr_req), .keypad_present(kp_pres),
    .external_clear_line(ext_clr), .forward_run_cmd(fwd), .reverse_run_cmd(rev));

  // short loss time keeps the run brief; expectations follow from 20
  dcks_top #(.LOSS_CYCLES(20)) u_dcks_top (.clk_sys(clk_sys), .rst(rst),
    .sel_wr_stb(sel_wr_stb), .sel_wr_data(sel_wr_data), .comm_clear_stb(comm_clear_stb),
    .keypad_clear_stb(keypad_clear_stb), .keypad_stop_stb(keypad_stop_stb),
    .stop_from_selected(stop_from_selected), .stop_unit_id(stop_unit_id),
    .release_stb(release_stb), .release_unit_id(release_unit_id), .op_mode(op_mode),
    .keypad_jog_active(jog), .serial_multidrop_mode(mdrop), .motor_stopped(motor_stopped),
    .coast_stop_select(coast_stop_select), .other_fault_stb(1'b0), .keypad_present(kp_pres),
    .external_clear_line(ext_clr), .forward_run_cmd(fwd), .reverse_run_cmd(rev),
    .fault_clear_stop_select_q(sel_q), .fault_out_q(fault), .panel_loss_fault_q(loss),
    .panel_stop_state_q(pstop), .out_stage_en_q(out_en), .coast_q(coast),
    .decel_req_q(decel), .run_allowed_q(run_ok), .thermal_clear_q(therm),
    .regen_clear_q(regen));

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [4:0] e, logic [4:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle strobe; returns just after the edge where its answer lands
  task automatic pulse(int k);
    @(posedge clk_sys);
    case (k)
      0: comm_clear_stb <= 1'b1;
      1: keypad_clear_stb <= 1'b1;
      2: keypad_stop_stb <= 1'b1;
      3: release_stb <= 1'b1;
      default: sel_wr_stb <= 1'b1;
    endcase
    @(posedge clk_sys);
    {comm_clear_stb, keypad_clear_stb, keypad_stop_stb, release_stb, sel_wr_stb} <= 5'h00;
    #1;
  endtask

  task automatic wsel(logic [4:0] v);
    @(posedge clk_sys);
    sel_wr_data <= v;
    pulse(4);
  endtask

  task automatic t_sel;
    logic [4:0] e;
    e = 5'h0e;
    for (int i = 0; i < 32; i++) begin
      wsel(i[4:0]);
      if (i < 4 || (i > 13 && i < 18)) e = i[4:0];
      chk("selector", e, sel_q);
    end
  endtask

  task automatic t_clear;
    wsel(5'h0f);
    pulse(0);
    chk("thermal_clear refused", 5'h00, therm);
    pulse(1);
    chk("keypad clear refused", 5'h00, therm);
    wsel(5'h0e);
    pulse(0);
    chk("thermal_clear", 5'h01, therm);
    chk("regen_clear", 5'h01, regen);
    chk("out_stage_en off", 5'h00, out_en);
    chk("coast", 5'h01, coast);
    cyc(1);
    #1;
    chk("out_stage_en back", 5'h01, out_en);
  endtask

  task automatic t_pstop;
    @(posedge clk_sys);
    run_req <= 1'b1;
    cyc(4);
    pulse(2);
    chk("panel_stop", 5'h01, pstop);
    chk("fault_out", 5'h00, fault);
    chk("decel_req", 5'h01, decel);
    chk("coast", 5'h00, coast);
    chk("run_allowed", 5'h00, run_ok);
    @(posedge clk_sys);
    motor_stopped <= 1'b1;
    run_req <= 1'b0;
    release_unit_id <= 1'b0;
    cyc(4);
    pulse(3);
    chk("panel_stop other unit", 5'h01, pstop);
    @(posedge clk_sys);
    release_unit_id <= 1'b1;
    pulse(3);
    chk("panel_stop released", 5'h00, pstop);
    chk("run_allowed", 5'h01, run_ok);
    pulse(2);
    @(posedge clk_sys);
    clr_req <= 1'b1;
    cyc(6);
    #1;
    chk("panel_stop line clear", 5'h00, pstop);
    @(posedge clk_sys);
    clr_req <= 1'b0;
  endtask

  task automatic t_nopstop;
    wsel(5'h00);
    @(posedge clk_sys);
    motor_stopped <= 1'b0;
    pulse(2);
    chk("panel_stop sel0", 5'h00, pstop);
    chk("decel outside", 5'h00, decel);
    @(posedge clk_sys);
    op_mode <= DCKS_MODE_KEYPAD;
    stop_from_selected <= 1'b0;
    pulse(2);
    chk("decel keypad", 5'h01, decel);
    chk("panel_stop sel0", 5'h00, pstop);
    wsel(5'h0e);
    pulse(2);
    chk("panel_stop other source", 5'h01, pstop);
    pulse(0);
    chk("panel_stop clear", 5'h00, pstop);
  endtask

  task automatic t_loss;
    wsel(5'h10);
    cyc(40);
    chk("fault absent at start", 5'h00, fault);
    @(posedge clk_sys);
    plug_req <= 1'b1;
    cyc(6);
    plug_req <= 1'b0;
    cyc(12);
    #1;
    chk("fault early", 5'h00, fault);
    for (int i = 0; i < 30 && fault !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("fault loss", 5'h01, fault);
    chk("panel_loss_fault", 5'h01, loss);
    @(posedge clk_sys);
    plug_req <= 1'b1;
    cyc(6);
    #1;
    chk("fault held", 5'h01, fault);
    chk("out_stage_en held", 5'h00, out_en);
    pulse(1);
    chk("fault cleared", 5'h00, fault);
    chk("panel_loss_fault", 5'h00, loss);
    wsel(5'h0e);
    @(posedge clk_sys);
    plug_req <= 1'b0;
    cyc(40);
    #1;
    chk("fault continue", 5'h00, fault);
  endtask

  task automatic t_jog_mdrop;
    wsel(5'h10);
    @(posedge clk_sys);
    mdrop <= 1'b1;
    plug_req <= 1'b1;
    cyc(6);
    plug_req <= 1'b0;
    cyc(40);
    #1;
    chk("fault multidrop", 5'h00, fault);
    @(posedge clk_sys);
    plug_req <= 1'b1;
    cyc(6);
    mdrop <= 1'b0;
    wsel(5'h0e);
    @(posedge clk_sys);
    motor_stopped <= 1'b0;
    jog <= 1'b1;
    cyc(1);
    plug_req <= 1'b0;
    cyc(6);
    #1;
    chk("decel jog loss", 5'h01, decel);
    chk("fault jog loss", 5'h00, fault);
    @(posedge clk_sys);
    motor_stopped <= 1'b1;
    jog <= 1'b0;
    cyc(2);
    #1;
    chk("decel jog done", 5'h00, decel);
    chk("run_allowed jog done", 5'h01, run_ok);
    @(posedge clk_sys);
    op_mode <= DCKS_MODE_NETWORK;
    pulse(2);
    chk("panel_stop network", 5'h01, pstop);
    pulse(0);
    chk("panel_stop network clear", 5'h00, pstop);
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    final_report();
  end

  initial begin
    cyc(8);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("selector reset", 5'h0e, sel_q);
    chk("run_allowed reset", 5'h01, run_ok);
    t_sel();
    t_clear();
    t_pstop();
    t_nopstop();
    t_loss();
    t_jog_mdrop();
    final_report();
  end
endmodule
